// >>> rtl/pwm_generator_control_duty.sv
`timescale 1ns/1ps
module pwm_generator_control_duty
   import pwm_gen_pkg::*;
#(
   parameter logic [15:0] KEY_A = KEY_FIRST,
   parameter logic [15:0] KEY_B = KEY_SECOND
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic fault_event,
   input wire logic current_limit_event,
   input wire logic current_limit_mode,
   input wire logic primary_sync,
   input wire logic secondary_sync,
   input wire logic secondary_available,
   output pwm_out_s pwm_out,
   output logic trigger_event,
   output logic irq_request
);

   // bus phase capture
   logic wr_pend;
   logic [7:0] wr_addr;
   logic [15:0] master_duty_value;
   logic [15:0] lock_key_value;
   logic [15:0] generator_control;
   logic [15:0] generator_duty_value;
   logic [15:0] master_period_value;
   logic [15:0] phase_offset_value;
   logic [15:0] secondary_duty_value;
   logic [13:0] deadtime_value;
   logic [1:0] output_control;
   logic module_run_enable;
   key_state_e key_state;
   active_s act;
   logic [15:0] tb_count;
   logic [15:0] period;
   logic cycle_end;
   logic tb_sync;
   logic raw_high;
   logic raw_low;
   logic [13:0] dt_count;
   logic prev_raw;

   function automatic logic [15:0] clamp_duty(input logic [15:0] d, input logic [15:0] p);
      logic [15:0] hi;
      hi = p - MIN_PULSE;
      if (d < MIN_PULSE) begin
         clamp_duty = MIN_PULSE;
      end else if (d > hi) begin
         clamp_duty = hi;
      end else begin
         clamp_duty = d;
      end
   endfunction

   function automatic logic [15:0] coarsen(input logic [15:0] d, input logic [15:0] p,
                                           input logic independent);
      logic near;
      near = (d < MIN_PULSE + EDGE_BAND) || (d > p - MIN_PULSE - EDGE_BAND);
      if (!near) begin
         coarsen = d;
      end else if (independent) begin
         coarsen = d & COARSE_MASK_1;
      end else begin
         coarsen = d & COARSE_MASK_3;
      end
   endfunction

   logic bus_take;
   logic [15:0] wdata;
   logic unlocked;
   logic center_mode;
   logic local_mode;
   assign bus_take = hsel && hready && htrans[1];
   assign wdata = hwdata[15:0];
   assign unlocked = (key_state == KEY_OPEN);
   assign local_mode = generator_control[BIT_LOCAL_PER];
   assign center_mode = local_mode && generator_control[BIT_CENTER];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // address phase latch; slave is always zero wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= bus_take && hwrite;
         if (bus_take) begin
            wr_addr <= haddr[7:0];
         end
      end
   end

   logic wr_ctrl;
   assign wr_ctrl = wr_pend && (wr_addr == OFS_GEN_CONTROL) && unlocked;

   // unlock sequence, one protected write consumes it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         key_state <= KEY_LOCKED;
      end else if (wr_pend && wr_addr == OFS_LOCK_KEY) begin
         if (wdata == KEY_A) begin
            key_state <= KEY_HALF;
         end else if (key_state == KEY_HALF && wdata == KEY_B) begin
            key_state <= KEY_OPEN;
         end else begin
            key_state <= KEY_LOCKED;
         end
      end else if (wr_ctrl) begin
         key_state <= KEY_LOCKED;
      end
   end

   // plain read/write registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         master_duty_value <= RST_ZERO;
         lock_key_value <= RST_ZERO;
         generator_duty_value <= RST_ZERO;
         master_period_value <= RST_PERIOD;
         phase_offset_value <= RST_ZERO;
         secondary_duty_value <= RST_ZERO;
         deadtime_value <= 14'h0000;
         output_control <= 2'h0;
         module_run_enable <= 1'b0;
      end else if (wr_pend) begin
         unique case (wr_addr)
            OFS_MASTER_DUTY: master_duty_value <= wdata;
            OFS_LOCK_KEY: lock_key_value <= wdata;
            OFS_GEN_DUTY: generator_duty_value <= wdata;
            OFS_MASTER_PERIOD: master_period_value <= wdata;
            OFS_PHASE: phase_offset_value <= wdata;
            OFS_SECONDARY_DUTY: secondary_duty_value <= wdata;
            OFS_DEADTIME: deadtime_value <= wdata[13:0];
            OFS_OUTPUT_CONTROL: output_control <= wdata[1:0];
            OFS_RUN_CONTROL: module_run_enable <= wdata[15];
            default: ;
         endcase
      end
   end

   // control register: writing an enable low clears its hardware status flag even against a same-cycle event
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         generator_control <= RST_ZERO;
      end else begin
         if (wr_ctrl) begin
            generator_control[12:0] <= wdata[12:0] & CTRL_WMASK[12:0];
         end
         // writing an enable low clears its flag, even if an event arrives now
         if (fault_event && (wr_ctrl ? wdata[BIT_FLT_IEN] : generator_control[BIT_FLT_IEN]))
            generator_control[BIT_FLT_PEND] <= 1'b1;
         else if (wr_ctrl && !wdata[BIT_FLT_IEN])
            generator_control[BIT_FLT_PEND] <= 1'b0;
         if (current_limit_event && (wr_ctrl ? wdata[BIT_CL_IEN] : generator_control[BIT_CL_IEN]))
            generator_control[BIT_CL_PEND] <= 1'b1;
         else if (wr_ctrl && !wdata[BIT_CL_IEN])
            generator_control[BIT_CL_PEND] <= 1'b0;
         if (trigger_event && (wr_ctrl ? wdata[BIT_TRG_IEN] : generator_control[BIT_TRG_IEN]))
            generator_control[BIT_TRG_PEND] <= 1'b1;
         else if (wr_ctrl && !wdata[BIT_TRG_IEN])
            generator_control[BIT_TRG_PEND] <= 1'b0;
      end
   end

   // the interrupt controller flag is cleared separately by software
   assign irq_request = |generator_control[15:13];

   // read mux, data held stable for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (bus_take && !hwrite) begin
         unique case (haddr[7:0])
            OFS_MASTER_DUTY: hrdata <= {16'h0000, master_duty_value};
            OFS_LOCK_KEY: hrdata <= {16'h0000, lock_key_value};
            OFS_GEN_CONTROL: hrdata <= {16'h0000, generator_control};
            OFS_GEN_DUTY: hrdata <= {16'h0000, generator_duty_value};
            OFS_MASTER_PERIOD: hrdata <= {16'h0000, master_period_value};
            OFS_PHASE: hrdata <= {16'h0000, phase_offset_value};
            OFS_SECONDARY_DUTY: hrdata <= {16'h0000, secondary_duty_value};
            OFS_DEADTIME: hrdata <= {18'h00000, deadtime_value};
            OFS_OUTPUT_CONTROL: hrdata <= {30'h0000_0000, output_control};
            OFS_RUN_CONTROL: hrdata <= {16'h0000, module_run_enable, 15'h0000};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // period and sync source selection
   always_comb begin
      period = local_mode ? act.phase : master_period_value;
      if (generator_control[BIT_TB_SRC] && secondary_available) begin
         tb_sync = secondary_sync;
      end else begin
         tb_sync = primary_sync;
      end
   end

   logic ext_restart;
   assign ext_restart = generator_control[BIT_EXT_RESET] && local_mode
                        && !current_limit_mode && current_limit_event;
   assign cycle_end = module_run_enable && (ext_restart || (local_mode ?
                      (tb_count >= period) : tb_sync));

   // time base counter; master mode restarts on the chosen master sync
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tb_count <= RST_ZERO;
      end else if (!module_run_enable || cycle_end) begin
         tb_count <= RST_ZERO;
      end else if (center_mode) begin
         tb_count <= tb_count + (STEP_ONE << 3);
      end else begin
         tb_count <= tb_count + STEP_ONE;
      end
   end

   assign trigger_event = cycle_end;

   // active copies: immediate, at cycle boundary, or continuously while stopped
   logic [15:0] duty_src;
   logic [15:0] lsb_mask;
   assign duty_src = generator_control[BIT_SHARED_DUTY] ? master_duty_value
                                                        : generator_duty_value;
   assign lsb_mask = center_mode ? CENTER_MASK : 16'hFFFF;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         act <= '0;
      end else if (generator_control[BIT_IMMEDIATE] || cycle_end || !module_run_enable) begin
         act.duty <= duty_src & lsb_mask;
         act.sec_duty <= (generator_control[BIT_SHARED_DUTY] ? master_duty_value
                          : secondary_duty_value) & lsb_mask;
         act.phase <= phase_offset_value;
         act.deadtime <= deadtime_value & lsb_mask[13:0];
      end
   end

   // compare stage with clamp and coarsening
   logic indep;
   logic [15:0] eff_duty;
   logic [15:0] eff_sec;
   assign indep = (output_control == OUT_INDEPENDENT);
   assign eff_duty = coarsen(clamp_duty(act.duty, period), period, indep);
   assign eff_sec = coarsen(clamp_duty(act.sec_duty, period), period, indep);
   assign raw_high = module_run_enable && (tb_count < eff_duty);
   assign raw_low = module_run_enable && (tb_count < eff_sec);

   // dead-time counter restarts on every edge of the raw waveform
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dt_count <= 14'h0000;
         prev_raw <= 1'b0;
      end else begin
         prev_raw <= raw_high;
         if (raw_high != prev_raw) begin
            dt_count <= 14'h0000;
         end else if (dt_count != 14'h3FFF) begin
            dt_count <= dt_count + 14'h0001;
         end
      end
   end

   // output stage; registered so the pins never glitch
   logic dt_done;
   logic next_high;
   logic next_low;
   // zero dead time must not eat a cycle at every raw edge
   assign dt_done = (raw_high != prev_raw) ? (act.deadtime == 14'h0000)
                    : (({1'b0, dt_count} + 15'h0001) >= {1'b0, act.deadtime});
   always_comb begin
      next_high = raw_high;
      next_low = !raw_high;
      unique case (output_control)
         OUT_COMPLEMENTARY: begin
            unique case (deadtime_e'(generator_control[BIT_DTC_HI:BIT_DTC_LO]))
               DT_POSITIVE: begin
                  next_high = raw_high && dt_done;
                  next_low = !raw_high && dt_done;
               end
               DT_NEGATIVE: begin
                  next_high = raw_high || !dt_done;
                  next_low = !raw_high || !dt_done;
               end
               default: ; // disabled; reserved treated as disabled
            endcase
         end
         OUT_REDUNDANT: next_low = raw_high;
         OUT_PUSH_PULL: next_low = raw_high && tb_count[0];
         default: next_low = raw_low; // independent: own duty on low side
      endcase
      if (!module_run_enable) begin
         next_high = 1'b0;
         next_low = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwm_out <= '0;
      end else begin
         pwm_out.high_side_output <= next_high;
         pwm_out.low_side_output <= next_low;
      end
   end

   AST_FLT_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_ctrl && !wdata[BIT_FLT_IEN] && !fault_event |=> !generator_control[BIT_FLT_PEND])
      else $error("fault flag not cleared");
   AST_CL_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_ctrl && !wdata[BIT_CL_IEN] && !current_limit_event |=> !generator_control[BIT_CL_PEND])
      else $error("current-limit flag not cleared");
   AST_TRG_SET: assert property (@(posedge hclk) disable iff (!hresetn)
      trigger_event && generator_control[BIT_TRG_IEN] && !wr_ctrl
      |=> generator_control[BIT_TRG_PEND] && irq_request)
      else $error("trigger flag not set");
   AST_PERIOD_SEL: assert property (@(posedge hclk) disable iff (!hresetn)
      !local_mode |-> period == master_period_value)
      else $error("wrong period source");
   AST_CENTER_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
      center_mode && module_run_enable && !cycle_end ##1 center_mode
      |-> tb_count[2:0] == $past(tb_count[2:0]))
      else $error("center mode low bits moved");
   AST_MIN_PULSE: assert property (@(posedge hclk) disable iff (!hresetn)
      period >= 16'h0020 |-> eff_duty >= (MIN_PULSE & 16'hFFFC))
      else $error("pulse below minimum");
   AST_LATCH_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
      module_run_enable && !generator_control[BIT_IMMEDIATE] && !cycle_end
      |=> act.phase == $past(act.phase))
      else $error("active copy changed mid cycle");
   AST_RUN_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
      !module_run_enable ##1 !module_run_enable |-> pwm_out == '0)
      else $error("output active while stopped");
   AST_KEY_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend && wr_addr == OFS_GEN_CONTROL && !unlocked
      |=> generator_control[12:0] == $past(generator_control[12:0]))
      else $error("locked control register changed");
   COV_TRG: cover property (@(posedge hclk) disable iff (!hresetn)
      generator_control[BIT_TRG_PEND] ##[1:20] !generator_control[BIT_TRG_PEND]);
   COV_CENTER: cover property (@(posedge hclk) disable iff (!hresetn)
      center_mode && cycle_end);
   COV_EXT: cover property (@(posedge hclk) disable iff (!hresetn) ext_restart);
   COV_INDEP: cover property (@(posedge hclk) disable iff (!hresetn)
      indep && pwm_out.low_side_output);

endmodule // pwm_generator_control_duty

// >>> rtl/pwm_gen_pkg.sv
package pwm_gen_pkg;
   // register byte addresses
   localparam logic [7:0] OFS_MASTER_DUTY = 8'h00;
   localparam logic [7:0] OFS_LOCK_KEY = 8'h04;
   localparam logic [7:0] OFS_GEN_CONTROL = 8'h08;
   localparam logic [7:0] OFS_GEN_DUTY = 8'h0C;
   localparam logic [7:0] OFS_MASTER_PERIOD = 8'h10;
   localparam logic [7:0] OFS_PHASE = 8'h14;
   localparam logic [7:0] OFS_SECONDARY_DUTY = 8'h18;
   localparam logic [7:0] OFS_DEADTIME = 8'h1C;
   localparam logic [7:0] OFS_OUTPUT_CONTROL = 8'h20;
   localparam logic [7:0] OFS_RUN_CONTROL = 8'h24;
   // generator_control field positions
   localparam int BIT_FLT_PEND = 15;
   localparam int BIT_CL_PEND = 14;
   localparam int BIT_TRG_PEND = 13;
   localparam int BIT_FLT_IEN = 12;
   localparam int BIT_CL_IEN = 11;
   localparam int BIT_TRG_IEN = 10;
   localparam int BIT_LOCAL_PER = 9;
   localparam int BIT_SHARED_DUTY = 8;
   localparam int BIT_DTC_HI = 7;
   localparam int BIT_DTC_LO = 6;
   localparam int BIT_TB_SRC = 3;
   localparam int BIT_CENTER = 2;
   localparam int BIT_EXT_RESET = 1;
   localparam int BIT_IMMEDIATE = 0;
   localparam logic [15:0] CTRL_WMASK = 16'h1FCF;
   // reset values
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam logic [15:0] RST_PERIOD = 16'hFFF8;
   // pulse width limits and center-align granularity
   localparam logic [15:0] MIN_PULSE = 16'h0008;
   localparam logic [15:0] CENTER_MASK = 16'hFFF8;
   localparam logic [15:0] STEP_ONE = 16'h0001;
   // resolution coarsening band near 0 % and 100 %
   localparam int CLK_PERIOD_NS = 10;
   localparam int EDGE_BAND_NS = 40;
   localparam int EDGE_BAND_CYC = EDGE_BAND_NS / CLK_PERIOD_NS;
   localparam logic [15:0] EDGE_BAND = 16'(EDGE_BAND_CYC);
   localparam logic [15:0] COARSE_MASK_1 = 16'hFFFE;
   localparam logic [15:0] COARSE_MASK_3 = 16'hFFFC;
   // unlock key sequence defaults
   localparam logic [15:0] KEY_FIRST = 16'h1234;
   localparam logic [15:0] KEY_SECOND = 16'hEDCB;

   typedef enum logic [1:0] {
      OUT_COMPLEMENTARY = 2'h0,
      OUT_REDUNDANT = 2'h1,
      OUT_PUSH_PULL = 2'h2,
      OUT_INDEPENDENT = 2'h3
   } out_mode_e;

   typedef enum logic [1:0] {
      DT_POSITIVE = 2'h0,
      DT_NEGATIVE = 2'h1,
      DT_DISABLED = 2'h2,
      DT_RESERVED = 2'h3
   } deadtime_e;

   typedef enum logic [1:0] {
      KEY_LOCKED = 2'b00,
      KEY_HALF = 2'b01,
      KEY_OPEN = 2'b11
   } key_state_e;

   // active copies that only change at a cycle boundary, at once, or while the module is stopped
   typedef struct packed {
      logic [15:0] duty;
      logic [15:0] sec_duty;
      logic [15:0] phase;
      logic [13:0] deadtime;
   } active_s;

   typedef struct packed {
      logic high_side_output;
      logic low_side_output;
   } pwm_out_s;
endpackage

// >>> dv/power_stage_model.sv
`timescale 1ns/1ps
module power_stage_model
   import pwm_gen_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire pwm_out_s pwm_out,
   input wire logic trip_fault,
   input wire logic trip_limit,
   output logic fault_event,
   output logic current_limit_event,
   output logic [15:0] high_width
);
   logic [15:0] run_len;

   // width of each high-side pulse, latched when the pulse ends
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_len <= 16'h0000;
         high_width <= 16'h0000;
      end else if (pwm_out.high_side_output) begin
         run_len <= run_len + 16'h0001;
      end else begin
         if (run_len != 16'h0000) high_width <= run_len;
         run_len <= 16'h0000;
      end
   end

   // the stage only trips when the bench commands it, one cycle per event
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fault_event <= 1'b0;
         current_limit_event <= 1'b0;
      end else begin
         fault_event <= trip_fault;
         current_limit_event <= trip_limit;
      end
   end
endmodule // power_stage_model

// >>> dv/pwm_generator_control_duty_tb_top.sv
`timescale 1ns/1ps
module pwm_generator_control_duty_tb_top
   import pwm_gen_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic fault_event, current_limit_event, primary_sync, trigger_event, irq_request;
   logic trip_fault, trip_limit;
   logic [7:0] sync_cnt;
   logic [15:0] high_width, rd, d;
   logic [31:0] seed;
   pwm_out_s pwm_out;
   int fail_count, check_count;

   assign hready = hreadyout;
   pwm_generator_control_duty dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .fault_event(fault_event), .current_limit_event(current_limit_event),
      .current_limit_mode(1'b0),
      .primary_sync(primary_sync), .secondary_sync(1'b0), .secondary_available(1'b0),
      .pwm_out(pwm_out), .trigger_event(trigger_event), .irq_request(irq_request));
   power_stage_model stage (.hclk(hclk), .hresetn(hresetn), .pwm_out(pwm_out),
      .trip_fault(trip_fault), .trip_limit(trip_limit), .fault_event(fault_event),
      .current_limit_event(current_limit_event), .high_width(high_width));

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // master time base boundary every 256 cycles
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_cnt <= 8'h00;
         primary_sync <= 1'b0;
      end else begin
         sync_cnt <= sync_cnt + 8'h01;
         primary_sync <= (sync_cnt == 8'h00);
      end
   end

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // pulse width expected after clamping to the legal band
   function automatic logic [15:0] exp_width(input logic [15:0] dv, input logic [15:0] p);
      if (dv < MIN_PULSE) return MIN_PULSE;
      if (dv > p - MIN_PULSE) return p - MIN_PULSE;
      return dv;
   endfunction

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one single AHB-Lite transfer; the slave may stretch either phase
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      htrans <= 2'b10;
      hsize <= 3'b010;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {16'h0000, wd};
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata[15:0];
   endtask

   task automatic ctrl_write(input logic [15:0] v);
      bus(1'b1, OFS_LOCK_KEY, KEY_FIRST);
      bus(1'b1, OFS_LOCK_KEY, KEY_SECOND);
      bus(1'b1, OFS_GEN_CONTROL, v);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      #200000;
      fail_count++;
      conclude();
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      hwrite = 1'b0;
      htrans = 2'b00;
      hsize = 3'b010;
      hwdata = 32'h00000000;
      trip_fault = 1'b0;
      trip_limit = 1'b0;
      seed = 32'h723D494F;
      fail_count = 0;
      check_count = 0;
      wait_cyc(2);
      hresetn <= 1'b1;
      @(posedge hclk);
      // register reset values and the unmapped hole
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, 8'(4 * i), 16'h0000);
         chk("reset value", rd, RST_ZERO);
      end
      bus(1'b1, 8'h30, 16'hBEEF);
      bus(1'b0, 8'h30, 16'h0000);
      chk("unmapped", rd, 16'h0000);
      $display("test reset done");
      // random read-back of the master duty and lock key words
      repeat (4) begin
         seed = xorshift(seed);
         bus(1'b1, OFS_MASTER_DUTY, seed[15:0]);
         bus(1'b1, OFS_LOCK_KEY, seed[31:16]);
         bus(1'b0, OFS_MASTER_DUTY, 16'h0000);
         chk("master duty", rd, seed[15:0]);
         bus(1'b0, OFS_LOCK_KEY, 16'h0000);
         chk("key", rd, seed[31:16]);
      end
      $display("test readback done");
      // control stays locked without the key sequence
      bus(1'b1, OFS_GEN_CONTROL, 16'h1E01);
      bus(1'b0, OFS_GEN_CONTROL, 16'h0000);
      chk("locked control", rd, 16'h0000);
      // local period, immediate update, all interrupt enables; set before run
      ctrl_write(16'h1E01);
      bus(1'b0, OFS_GEN_CONTROL, 16'h0000);
      chk("control", rd & CTRL_WMASK, 16'h1E01);
      bus(1'b1, OFS_PHASE, 16'h0040);
      bus(1'b1, OFS_RUN_CONTROL, 16'h8000);
      // boundary duties then random ones
      for (int k = 0; k < 6; k++) begin
         seed = xorshift(seed);
         d = (k == 0) ? 16'h0002 : (k == 1) ? 16'h003E : 16'h0010 + (seed[15:0] & 16'h001F);
         bus(1'b1, OFS_GEN_DUTY, d);
         wait_cyc(300);
         chk("pulse width", high_width, exp_width(d, 16'h0040));
         chk("low side", 16'(pwm_out.low_side_output), 16'(!pwm_out.high_side_output));
      end
      $display("test duty done");
      // each time base cycle end raises the trigger flag
      bus(1'b0, OFS_GEN_CONTROL, 16'h0000);
      chk("trigger pending", {15'h0000, rd[BIT_TRG_PEND]}, 16'h0001);
      chk("irq", {15'h0000, irq_request}, 16'h0001);
      trip_fault <= 1'b1;
      trip_limit <= 1'b1;
      @(posedge hclk);
      trip_fault <= 1'b0;
      trip_limit <= 1'b0;
      wait_cyc(3);
      bus(1'b0, OFS_GEN_CONTROL, 16'h0000);
      chk("fault pending", {15'h0000, rd[BIT_FLT_PEND]}, 16'h0001);
      chk("limit pending", {15'h0000, rd[BIT_CL_PEND]}, 16'h0001);
      // software clears the flags by dropping the enables
      bus(1'b1, OFS_RUN_CONTROL, 16'h0000);
      ctrl_write(16'h0301);
      bus(1'b0, OFS_GEN_CONTROL, 16'h0000);
      chk("flags cleared", rd & 16'hE000, 16'h0000);
      chk("irq cleared", {15'h0000, irq_request}, 16'h0000);
      $display("test flags done");
      // shared duty value replaces the generator's own
      bus(1'b1, OFS_MASTER_DUTY, 16'h0018);
      bus(1'b1, OFS_RUN_CONTROL, 16'h8000);
      wait_cyc(300);
      chk("shared duty width", high_width, 16'h0018);
      $display("test shared duty done");
      // shared master period restarted by the primary sync; secondary unavailable
      bus(1'b1, OFS_RUN_CONTROL, 16'h0000);
      ctrl_write(16'h0009);
      bus(1'b1, OFS_GEN_DUTY, 16'h0024);
      bus(1'b1, OFS_RUN_CONTROL, 16'h8000);
      wait_cyc(600);
      chk("master period width", high_width, exp_width(16'h0024, RST_PERIOD));
      $display("test master period done");
      conclude();
   end
endmodule // pwm_generator_control_duty_tb_top
